// ===== bhw_pkg.sv
// package of shared constants and carrier types for the radio wake/power block
// assumes: single 40 MHz clock, AXI4-Lite register access
package bhw_pkg;
    // =========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00; // control register
    localparam logic [7:0] LINK_OFS = 8'h04; // link command register
    localparam logic [7:0] TEST_OFS = 8'h08; // test mode register
    localparam logic [7:0] STAT_OFS = 8'h0C; // status register
    localparam logic [7:0] PWR_OFS = 8'h10; // power-down override register
    // =========================================================
    // control field positions
    localparam int CTRL_WAKE_EN = 0; // use host wake-request input pin
    localparam int CTRL_IN_POL = 1; // host wake-request active level
    localparam int CTRL_OUT_POL = 2; // host wake output active level
    localparam int CTRL_PAD_OK = 3; // pad function configured
    localparam int CTRL_EXT_REF = 4; // host supplies reference clock
    localparam int CTRL_HOST_WAKE = 5; // firmware asks host to wake
    localparam int CTRL_SLEEP_OK = 6; // own sleep criteria met
    localparam int CTRL_INIT_DONE = 7; // initialization complete
    localparam logic [31:0] CTRL_RST = 32'h0000_0000; // control reset value
    // test register fields
    localparam int TEST_MODE_LSB = 0; // two-bit test mode
    localparam int TEST_PAT_LSB = 8; // eight-bit fixed pattern
    localparam int TEST_PRBS = 16; // select prbs-9
    localparam int TEST_CHAN_LSB = 24; // seven-bit fixed channel
    // =========================================================
    // timing
    localparam int CLK_HZ = 40_000_000; // system clock rate
    localparam int HOP_RATE = 1600; // hops per second
    localparam int HOP_CYC = CLK_HZ / HOP_RATE; // cycles per hop slot
    localparam int NUM_CHAN = 79; // hop channels
    localparam int SETTLE_US = 100; // hop settling time, us
    localparam int SETTLE_CYC = (SETTLE_US * 40); // cycles at 40 per us
    localparam int REF_SETTLE_US = 1000; // reference clock settling, us
    localparam int REF_SETTLE_CYC = REF_SETTLE_US * 40; // cycles
    localparam logic [8:0] PRBS_SEED = 9'h1FF; // prbs-9 seed
    // =========================================================
    // enumerations
    typedef enum logic [1:0] {TM_OFF, TM_CARRIER, TM_CONST_RX, TM_CONST_TX} bhw_test_t;
    typedef enum logic [2:0] {LC_IDLE, LC_CONN, LC_PAGE, LC_PSCAN, LC_INQ, LC_ISCAN,
                              LC_SNIFF} bhw_link_t;
    typedef enum logic [2:0] {PS_OFF, PS_REFREQ, PS_SETTLE, PS_INIT, PS_READY} bhw_pwr_t;
    // power-down controls to the transceiver
    typedef struct packed {
        logic tx_pd;
        logic rx_pd;
        logic pll_pd;
        logic pa_pd;
    } bhw_rfpd_t;
endpackage

// ===== bhw_prbs.sv
// prbs-9 / fixed pattern serial generator for constant transmit test
// assumes: advanced on each cycle that the caller's bit enable is high
`timescale 1ns/100ps
module bhw_prbs (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_bit_en,
    input wire logic i_use_prbs,
    input wire logic [7:0] i_pattern,
    output logic o_bit
);
    typedef struct packed {
        logic [8:0] lfsr;
        logic [2:0] idx;
        logic bit_q;
    } bhw_prbs_st_t;
    bhw_prbs_st_t st_reg, st_next;
    // =========================================================
    // next-state: x^9 + x^5 + 1 or repeating byte
    always_comb begin
        st_next = st_reg;
        if (i_bit_en) begin
            if (i_use_prbs) begin // prbs-9 sequence
                st_next.bit_q = st_reg.lfsr[8];
                st_next.lfsr = {st_reg.lfsr[7:0], st_reg.lfsr[8] ^ st_reg.lfsr[4]};
            end else begin // fixed byte, msb first
                st_next.bit_q = i_pattern[3'h7 - st_reg.idx];
                st_next.idx = st_reg.idx + 3'h1;
            end
        end
    end
    // state register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_reg <= '{lfsr: bhw_pkg::PRBS_SEED, idx: 3'h0, bit_q: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end
    assign o_bit = st_reg.bit_q;
    // lfsr never locks at zero
    a_lfsr_nonzero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st_reg.lfsr != 9'h000) else $error("prbs register reached zero"); // R8
endmodule // bhw_prbs

// ===== bhw_sync.sv
// two-flop synchroniser for asynchronous pin levels
// assumes: one destination clock
`timescale 1ns/100ps
module bhw_sync #(
    parameter int WIDTH = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bhw_sync_st_t;
    bhw_sync_st_t st_reg, st_next;
    // =========================================================
    // first stage feeds only the second
    always_comb begin
        st_next.meta = i_async;
        st_next.stable = st_reg.meta;
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign o_sync = st_reg.stable;
endmodule // bhw_sync

// ===== bhw_power_ctrl.sv
// radio wake handshake, power-up sequencing, rf power-down, link state and test modes
// assumes: AXI4-Lite master on i_sys_clk; wake request, power enable and cts pins are asynchronous and synchronised here
// Function
// R1 - hop timer: 1600 hops/s, 79 channels
// R2 - self calibration inside each hop settle
// R3 - receive path processing enabled per packet
// R4 - transmit path processing enabled per packet
// R5 - command controller drives link states, substates
// R6 - test: unmodulated carrier on fixed channel
// R7 - test: receiver output routed to pin
// R8 - test: fixed byte or prbs-9 transmit
// R9 - power actions from registers or packets
// R10 - separate tx, rx, pll, pa power-downs
// R11 - wake pins enabled by configuration
// R12 - wake request asserted keeps device awake
// R13 - sleep only if request off, criteria met
// R14 - host stays awake while wake output asserted
// R15 - software selects both wake pin polarities
// R16 - clock request high if radio/wlan need
// R17 - firmware sets pad function to zero
// R18 - host raises power enable after io setup
// R19 - clock request after power enable, external ref
// R20 - io settle after reference settling time
// R21 - rts low after init and cts low
// R22 - wake request synchronised before use
// R23 - outputs held off until configured
`timescale 1ns/100ps
module bhw_power_ctrl #(
    parameter int REF_SETTLE = bhw_pkg::REF_SETTLE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // axi4-lite slave
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // pins
    input wire logic i_host_to_radio_wake_request,
    output logic o_radio_to_host_wake_request,
    input wire logic i_radio_power_enable_in,
    output logic o_radio_refclk_request_pin,
    input wire logic i_wlan_refclk_need,
    output logic o_wlan_refclk_request_pin,
    input wire logic i_radio_uart_clear_to_send_n,
    output logic o_radio_uart_request_to_send_n,
    input wire logic i_rx_demod_bit,
    output logic o_radio_gpio_test,
    // baseband packet events and rf controls
    input wire logic i_pkt_tx_active,
    input wire logic i_pkt_rx_active,
    output bhw_pkg::bhw_rfpd_t o_rf_pd,
    output logic o_tx_bit,
    output logic o_tx_mod_en,
    output logic [6:0] o_hop_chan,
    output logic o_cal_strobe,
    output logic o_awake
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] test;
        logic [3:0] pd_force;
        bhw_pkg::bhw_link_t link;
        bhw_pkg::bhw_pwr_t pwr;
        logic [31:0] cnt;
        logic [15:0] hop_cnt;
        logic [6:0] chan;
        logic cal;
        logic awake;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] bresp;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic host_wake_q;
        logic refclk_q;
        logic rts_n_q;
        logic gpio_q;
    } bhw_st_t;
    bhw_st_t st_reg, st_next; // all state of the block
    logic [2:0] pin_s; // synchronised pin levels
    logic wake_req; // wake request after polarity
    logic prbs_bit; // serial test pattern
    logic bit_en; // one-bit-per-cycle test enable
    logic wr_fire; // write address and data both held
    // =========================================================
    // pin synchronisers
    bhw_sync #(.WIDTH(3)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async({i_host_to_radio_wake_request, i_radio_power_enable_in,
                  i_radio_uart_clear_to_send_n}), // R22
        .o_sync(pin_s)
    );
    assign wake_req = st_reg.ctrl[bhw_pkg::CTRL_WAKE_EN]
        & (pin_s[2] == st_reg.ctrl[bhw_pkg::CTRL_IN_POL]); // R11 R15
    assign bit_en = (st_reg.test[1:0] == 2'(bhw_pkg::TM_CONST_TX));
    // =========================================================
    // test pattern generator
    bhw_prbs u_prbs (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_bit_en(bit_en),
        .i_use_prbs(st_reg.test[bhw_pkg::TEST_PRBS]),
        .i_pattern(st_reg.test[bhw_pkg::TEST_PAT_LSB +: 8]),
        .o_bit(prbs_bit) // R8
    );
    assign wr_fire = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
    // =========================================================
    // next-state logic
    always_comb begin
        st_next = st_reg;
        // write address / data capture in either order
        if (i_awvalid && !st_reg.aw_got) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = i_awaddr;
        end
        if (i_wvalid && !st_reg.w_got) begin
            st_next.w_got = 1'b1;
            st_next.w_data = i_wdata;
        end
        if (wr_fire) begin // commit write
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = 2'h0;
            case (st_reg.aw_addr) // R9
                bhw_pkg::CTRL_OFS: st_next.ctrl = st_reg.w_data;
                bhw_pkg::LINK_OFS: st_next.link = bhw_pkg::bhw_link_t'(st_reg.w_data[2:0]); // R5
                bhw_pkg::TEST_OFS: st_next.test = st_reg.w_data;
                bhw_pkg::PWR_OFS: st_next.pd_force = st_reg.w_data[3:0];
                default: st_next.bresp = 2'h2; // slverr on unmapped
            endcase
        end else if (st_reg.bvalid && i_bready) begin
            st_next.bvalid = 1'b0;
        end
        // read channel
        if (i_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = 2'h0;
            case (i_araddr)
                bhw_pkg::CTRL_OFS: st_next.rdata = st_reg.ctrl;
                bhw_pkg::LINK_OFS: st_next.rdata = {29'h0, st_reg.link};
                bhw_pkg::TEST_OFS: st_next.rdata = st_reg.test;
                bhw_pkg::STAT_OFS: st_next.rdata = {16'h0, 1'b0, st_reg.chan,
                    1'b0, st_reg.pwr, st_reg.awake, wake_req, pin_s[1], pin_s[0]};
                bhw_pkg::PWR_OFS: st_next.rdata = {28'h0, st_reg.pd_force};
                default: begin
                    st_next.rdata = 32'h0000_0000;
                    st_next.rresp = 2'h2;
                end
            endcase
        end else if (st_reg.rvalid && i_rready) begin
            st_next.rvalid = 1'b0;
        end
        // power-up sequence
        case (st_reg.pwr)
            bhw_pkg::PS_OFF: begin // wait for host power enable
                st_next.cnt = 32'h0;
                if (pin_s[1]) begin // R18
                    st_next.pwr = bhw_pkg::PS_REFREQ;
                end
            end
            bhw_pkg::PS_REFREQ: begin // request clock first if external
                st_next.pwr = bhw_pkg::PS_SETTLE; // R19
            end
            bhw_pkg::PS_SETTLE: begin // wait reference settling
                st_next.cnt = st_reg.cnt + 32'h1;
                if (st_reg.cnt >= 32'(REF_SETTLE - 1)) begin // R20
                    st_next.pwr = bhw_pkg::PS_INIT;
                end
            end
            bhw_pkg::PS_INIT: begin // firmware init
                if (st_reg.ctrl[bhw_pkg::CTRL_INIT_DONE]) begin
                    st_next.pwr = bhw_pkg::PS_READY;
                end
            end
            bhw_pkg::PS_READY: begin
                if (!pin_s[1]) begin
                    st_next.pwr = bhw_pkg::PS_OFF;
                end
            end
            default: st_next.pwr = bhw_pkg::PS_OFF;
        endcase
        // sleep decision
        if (wake_req) begin
            st_next.awake = 1'b1; // R12
        end else if (st_reg.ctrl[bhw_pkg::CTRL_SLEEP_OK]) begin
            st_next.awake = 1'b0; // R13
        end else begin
            st_next.awake = 1'b1;
        end
        // hop timer and calibration window
        st_next.cal = 1'b0;
        if (st_reg.hop_cnt >= 16'(bhw_pkg::HOP_CYC - 1)) begin // R1
            st_next.hop_cnt = 16'h0;
            st_next.chan = (st_reg.chan >= 7'(bhw_pkg::NUM_CHAN - 1)) ? 7'h0
                : st_reg.chan + 7'h1;
        end else begin
            st_next.hop_cnt = st_reg.hop_cnt + 16'h1;
        end
        if (st_reg.hop_cnt == 16'(bhw_pkg::SETTLE_CYC / 2)) begin
            st_next.cal = 1'b1; // R2
        end
        // pin outputs
        st_next.host_wake_q = st_reg.ctrl[bhw_pkg::CTRL_PAD_OK]
            ? (st_reg.ctrl[bhw_pkg::CTRL_HOST_WAKE] ~^ st_reg.ctrl[bhw_pkg::CTRL_OUT_POL])
            : ~st_reg.ctrl[bhw_pkg::CTRL_OUT_POL]; // R14 R15 R23
        st_next.refclk_q = st_reg.ctrl[bhw_pkg::CTRL_PAD_OK]
            & st_reg.ctrl[bhw_pkg::CTRL_EXT_REF]
            & (st_reg.pwr != bhw_pkg::PS_OFF) & st_reg.awake; // R16 R19 R23
        st_next.rts_n_q = !((st_reg.pwr == bhw_pkg::PS_READY) && !pin_s[0]); // R21
        st_next.gpio_q = (st_reg.test[1:0] == 2'(bhw_pkg::TM_CONST_RX))
            ? i_rx_demod_bit : 1'b0; // R7
    end
    // =========================================================
    // state register
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_reg <= '0;
            st_reg.ctrl <= bhw_pkg::CTRL_RST;
            st_reg.rts_n_q <= 1'b1;
            st_reg.host_wake_q <= 1'b1;
            st_reg.link <= bhw_pkg::LC_IDLE;
            st_reg.pwr <= bhw_pkg::PS_OFF;
        end else begin
            st_reg <= st_next;
        end
    end
    // =========================================================
    // outputs
    assign o_awready = ~st_reg.aw_got;
    assign o_wready = ~st_reg.w_got;
    assign o_bvalid = st_reg.bvalid;
    assign o_bresp = st_reg.bresp;
    assign o_arready = ~st_reg.rvalid;
    assign o_rvalid = st_reg.rvalid;
    assign o_rdata = st_reg.rdata;
    assign o_rresp = st_reg.rresp;
    assign o_radio_to_host_wake_request = st_reg.host_wake_q;
    assign o_radio_refclk_request_pin = st_reg.refclk_q;
    assign o_wlan_refclk_request_pin = st_reg.ctrl[bhw_pkg::CTRL_PAD_OK]
        & (i_wlan_refclk_need | st_reg.refclk_q); // R16
    assign o_radio_uart_request_to_send_n = st_reg.rts_n_q;
    assign o_radio_gpio_test = st_reg.gpio_q;
    assign o_awake = st_reg.awake;
    assign o_hop_chan = (st_reg.test[1:0] != 2'(bhw_pkg::TM_OFF))
        ? st_reg.test[bhw_pkg::TEST_CHAN_LSB +: 7] : st_reg.chan; // R6
    assign o_cal_strobe = st_reg.cal;
    assign o_tx_mod_en = (st_reg.test[1:0] != 2'(bhw_pkg::TM_CARRIER)); // R6
    assign o_tx_bit = bit_en ? prbs_bit : 1'b0;
    // per-path power-down from packet handling, test mode, awake state or register force
    always_comb begin
        o_rf_pd.tx_pd = st_reg.pd_force[0] | ~(i_pkt_tx_active | bit_en
            | (st_reg.test[1:0] == 2'(bhw_pkg::TM_CARRIER))); // R4 R9 R10
        o_rf_pd.rx_pd = st_reg.pd_force[1] | ~(i_pkt_rx_active
            | (st_reg.test[1:0] == 2'(bhw_pkg::TM_CONST_RX))); // R3 R10
        o_rf_pd.pll_pd = st_reg.pd_force[2] | ~st_reg.awake; // R10
        o_rf_pd.pa_pd = st_reg.pd_force[3] | o_rf_pd.tx_pd; // R10
    end
    // =========================================================
    // checks
    a_wake_keeps: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        wake_req |=> st_reg.awake) else $error("awake lost under wake request"); // R12
    a_sleep_cause: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $fell(st_reg.awake) |-> $past(!wake_req && st_reg.ctrl[6]))
        else $error("slept without cause"); // R13
    a_rts_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (st_reg.pwr == bhw_pkg::PS_READY && !pin_s[0]) |=> !o_radio_uart_request_to_send_n)
        else $error("rts not lowered"); // R21
    a_rts_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (st_reg.pwr != bhw_pkg::PS_READY) |=> o_radio_uart_request_to_send_n)
        else $error("rts low too early"); // R21
    a_refclk_cfg: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !st_reg.ctrl[3] |=> !o_radio_refclk_request_pin)
        else $error("clock request before pad setup"); // R23
    a_settle_ok: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (st_reg.pwr == bhw_pkg::PS_SETTLE) ##1 (st_reg.pwr == bhw_pkg::PS_INIT)
        |-> $past(st_reg.cnt, 2) >= 32'(REF_SETTLE - 2))
        else $error("init before settling"); // R20
    a_chan_range: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st_reg.chan < 7'd79) else $error("hop channel out of range"); // R1
    a_wake_pol: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (st_reg.ctrl[3] && $stable(st_reg.ctrl)) |=>
        o_radio_to_host_wake_request == $past(st_reg.ctrl[5] ~^ st_reg.ctrl[2]))
        else $error("host wake level wrong"); // R15
    a_gpio_route: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (st_reg.test[1:0] == 2'h2) |=> o_radio_gpio_test == $past(i_rx_demod_bit))
        else $error("receiver bit not routed"); // R7
    a_pa_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_rf_pd.tx_pd |-> o_rf_pd.pa_pd) else $error("pa on with tx off"); // R10
    c_power_up: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st_reg.pwr == bhw_pkg::PS_INIT ##1 st_reg.pwr == bhw_pkg::PS_READY);
    c_sleep: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $fell(st_reg.awake));
    c_hop_wrap: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st_reg.chan == 7'd78 ##1 st_reg.chan == 7'd0 [*1]);
    c_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_bvalid && i_bready);
endmodule // bhw_power_ctrl

// ===== bhw_host_model.sv
// host side of the wake and power handshake, behavioural
// assumes: same clock as the radio block, bench steers it by levels
`timescale 1ns/100ps
module bhw_host_model #(
    parameter int IO_SETTLE = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_io_ready,
    input wire logic i_need,
    input wire logic i_in_pol,
    input wire logic i_wake_out,
    input wire logic i_out_pol,
    input wire logic i_cts_go,
    output logic o_wake_req,
    output logic o_pwr_en,
    output logic o_cts_n,
    output logic o_host_awake
);
    // ==========================================
    // power enable only after own io settling
    logic [3:0] cnt_reg; // settle counter
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cnt_reg <= 4'h0;
            o_pwr_en <= 1'b0;
        end else if (i_io_ready) begin
            if (cnt_reg != 4'(IO_SETTLE)) cnt_reg <= cnt_reg + 4'h1;
            else o_pwr_en <= 1'b1;
        end
    end
    // wake request at the chosen active level
    assign o_wake_req = i_need ? i_in_pol : ~i_in_pol;
    // host stays awake while radio wake output asserted
    assign o_host_awake = (i_wake_out == i_out_pol);
    // clear to send, active low
    assign o_cts_n = ~i_cts_go;
endmodule // bhw_host_model

// ===== bhw_power_ctrl_bench.sv
// self-checking bench for the radio wake/power block
// assumes: host model on the pins, axi4-lite tasks on the bus
`timescale 1ns/100ps
module bhw_power_ctrl_bench;
    // ==========================================
    // signals
    logic clk, rst_n, awv, wv, bry, arv, rry, io_rdy, need, inpol, outpol, ctsgo, rxb, wln, pkt;
    logic [7:0] awa, ara;
    logic [31:0] wd;
    logic awr, wr, bv, arr, rv, hw, pen, rref, cts_n, rts_n, gp, txb, men, cal, awk, wlp, wk, hawk;
    logic [1:0] br, rr;
    logic [31:0] rd, v;
    logic [6:0] ch;
    logic [1:0] resp;
    bhw_pkg::bhw_rfpd_t pd;
    int bad_count, n_tests, n_wait;
    // ==========================================
    // design and host model
    bhw_power_ctrl #(.REF_SETTLE(8)) i_dut (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF),
        .i_wvalid(wv), .o_wready(wr), .o_bresp(br), .o_bvalid(bv), .i_bready(bry),
        .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd), .o_rresp(rr),
        .o_rvalid(rv), .i_rready(rry), .i_host_to_radio_wake_request(wk),
        .o_radio_to_host_wake_request(hw), .i_radio_power_enable_in(pen),
        .o_radio_refclk_request_pin(rref), .i_wlan_refclk_need(wln),
        .o_wlan_refclk_request_pin(wlp), .i_radio_uart_clear_to_send_n(cts_n),
        .o_radio_uart_request_to_send_n(rts_n), .i_rx_demod_bit(rxb), .o_radio_gpio_test(gp),
        .i_pkt_tx_active(pkt), .i_pkt_rx_active(pkt), .o_rf_pd(pd), .o_tx_bit(txb),
        .o_tx_mod_en(men), .o_hop_chan(ch), .o_cal_strobe(cal), .o_awake(awk));
    bhw_host_model i_host (.i_sys_clk(clk), .i_rst_n(rst_n), .i_io_ready(io_rdy),
        .i_need(need), .i_in_pol(inpol), .i_wake_out(hw), .i_out_pol(outpol),
        .i_cts_go(ctsgo), .o_wake_req(wk), .o_pwr_en(pen), .o_cts_n(cts_n),
        .o_host_awake(hawk));
    // ==========================================
    // clock, 40 mhz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // compare and report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic finish_test();
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // axi write, releases each channel when taken
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int n;
        tb = 1'b0;
        n = 0;
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        while (!tb && n < 100) begin
            @(negedge clk);
            ta = awv && awr; tw = wv && wr; tb = bv; resp = br; n++;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) bry <= 1'b0;
        end
        if (!tb) chk("bvalid", 1, 0);
    endtask
    // axi read, data taken with rvalid
    task automatic rd_reg(input logic [7:0] a);
        logic ta, tr;
        int n;
        tr = 1'b0;
        n = 0;
        @(posedge clk);
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        while (!tr && n < 100) begin
            @(negedge clk);
            ta = arv && arr; tr = rv; v = rd; resp = rr; n++;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tr) rry <= 1'b0;
        end
        if (!tr) chk("rvalid", 1, 0);
    endtask
    // watchdog
    initial begin
        #(25 * 30000);
        bad_count++;
        finish_test();
    end
    // ==========================================
    // tests
    initial begin
        bad_count = 0; n_tests = 0; rst_n = 0; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0;
        awa = 0; ara = 0; wd = 0; io_rdy = 0; need = 0; inpol = 0; outpol = 0; ctsgo = 0;
        rxb = 0; wln = 0; pkt = 0;
        cyc(12);
        rst_n <= 1'b1;
        cyc(1);
        chk("rts_rst", 1, rts_n);
        chk("hwake_rst", 1, hw);
        chk("refreq_rst", 0, rref);
        // packet activity powers both paths while awake
        pkt <= 1'b1;
        cyc(1);
        chk("pkt_pd", 4'h0, pd);
        pkt <= 1'b0;
        rd_reg(bhw_pkg::CTRL_OFS);
        chk("ctrl_rst", bhw_pkg::CTRL_RST, v);
        rd_reg(8'h20);
        chk("unmapped", 2, resp);
        wr_reg(bhw_pkg::CTRL_OFS, 32'h0000_0018);
        wln <= 1'b1;
        cyc(2);
        chk("wlan_req", 1, wlp);
        wln <= 1'b0;
        io_rdy <= 1'b1;
        cyc(4);
        chk("no_pwr_yet", 0, pen);
        cyc(6);
        chk("refreq_on", 1, rref);
        cyc(12);
        rd_reg(bhw_pkg::STAT_OFS);
        chk("pwr_init", 3, v[6:4]);
        wr_reg(bhw_pkg::CTRL_OFS, 32'h0000_0098);
        cyc(2);
        rd_reg(bhw_pkg::STAT_OFS);
        chk("pwr_ready", 4, v[6:4]);
        chk("rts_wait", 1, rts_n);
        ctsgo <= 1'b1;
        cyc(5);
        chk("rts_low", 0, rts_n);
        wr_reg(bhw_pkg::CTRL_OFS, 32'h0000_00D9);
        cyc(5);
        chk("asleep", 0, awk);
        need <= 1'b1;
        cyc(5);
        chk("woken", 1, awk);
        inpol <= 1'b1;
        wr_reg(bhw_pkg::CTRL_OFS, 32'h0000_00FF);
        cyc(3);
        chk("pol_awake", 1, awk);
        outpol <= 1'b1;
        cyc(2);
        chk("hwake_hi", 1, hw);
        chk("host_awake", 1, hawk);
        wr_reg(bhw_pkg::CTRL_OFS, 32'h0000_00DF);
        cyc(2);
        chk("hwake_off", 0, hw);
        wr_reg(bhw_pkg::TEST_OFS, 32'h0500_0002);
        rxb <= 1'b1;
        cyc(3);
        chk("gpio_hi", 1, gp);
        chk("test_chan", 5, ch);
        rxb <= 1'b0;
        cyc(3);
        chk("gpio_lo", 0, gp);
        wr_reg(bhw_pkg::TEST_OFS, 32'h0300_0001);
        cyc(2);
        chk("carrier", 0, men);
        chk("carr_chan", 3, ch);
        // fixed byte sent msb first, one bit per cycle
        wr_reg(bhw_pkg::TEST_OFS, 32'h0000_A503);
        for (int i = 7; i >= 0; i--) begin
            cyc(1);
            v[i] = txb;
        end
        chk("tx_pattern", 32'h0000_00A5, {24'h0, v[7:0]});
        wr_reg(bhw_pkg::PWR_OFS, 32'h0000_000F);
        cyc(2);
        chk("rf_pd", 4'hF, pd);
        // calibration strobe comes once inside a hop slot
        n_wait = 0;
        while (!cal && n_wait < bhw_pkg::HOP_CYC) begin
            cyc(1);
            n_wait++;
        end
        chk("cal_seen", 1, cal);
        cyc(1);
        chk("cal_pulse", 0, cal);
        finish_test();
    end
endmodule // bhw_power_ctrl_bench
